// File: verilog/tcc_pkg.sv
// package with register map, field layout and reset values of the capture/compare timer
package tcc_pkg;
   // register addresses, compared directly with the slave bus address
   localparam logic [31:0] IDX_CTRL0    = 32'hFFFF_F26C;
   localparam logic [31:0] IDX_CTRL1    = 32'hFFFF_F270;
   localparam logic [31:0] IDX_EDGE0    = 32'hFFFF_F272;
   localparam logic [31:0] IDX_EDGE1    = 32'hFFFF_F292;
   localparam logic [31:0] IDX_CCR0     = 32'hFFFF_F274;
   localparam logic [31:0] IDX_CCR1     = 32'hFFFF_F276;
   localparam logic [31:0] IDX_COUNT    = 32'hFFFF_F278;
   localparam logic [31:0] IDX_ORIGIN   = 32'hFFFF_F27A;
   // control_reg0 fields
   localparam int          C0_GATE      = 0;
   localparam int          C0_RUN       = 1;
   localparam int          C0_CS_LO     = 4;
   localparam int          C0_CS_HI     = 6;
   localparam int          C0_OVF       = 7;
   localparam logic [7:0]  C0_RESET     = 8'h00;
   // output_and_mode_control fields
   localparam int          C1_MODE0     = 0;
   localparam int          C1_MODE1     = 1;
   localparam int          C1_CLR       = 3;
   localparam int          C1_POL       = 5;
   localparam int          C1_ENA       = 6;
   localparam logic [7:0]  C1_RESET     = 8'h20;
   localparam logic [7:0]  C1_WMASK     = 8'h6B;
   // edge select fields and codes
   localparam int          ES_IN0_LO    = 0;
   localparam int          ES_IN1_LO    = 2;
   localparam logic [7:0]  ES_RESET     = 8'h00;
   localparam logic [7:0]  ES_WMASK     = 8'h0F;
   localparam logic [1:0]  EDGE_FALL    = 2'h0;
   localparam logic [1:0]  EDGE_RISE    = 2'h1;
   localparam logic [1:0]  EDGE_BOTH    = 2'h3;
   // trigger origin select: bit 0 picks the frame start pulse for unit 0
   localparam int          OR_SOF       = 0;
   localparam logic [7:0]  OR_RESET     = 8'h00;
   localparam logic [15:0] CNT_ZERO     = 16'h0000;
   localparam logic [15:0] CNT_MAX      = 16'hFFFF;
endpackage

// File: verilog/tcc_unit.sv
// capture/compare timer unit with a memory-mapped register slave
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - pulse output held inactive while output enable is 0; matches still raise interrupts and clear.
// - enabled output changes on compare matches, inactive until first match.
// - polarity bit 0 gives active low, 1 active high; resets to 1.
// - clear enable with register 0 in compare clears counter on its match.
// - mode bit 1 for register 1, bit 0 for register 0; 0 capture.
// - two-bit edge fields: 00 falling, 01 rising, 11 both, 10 prohibited.
// - 16-bit free-running up-counter; matches raise interrupts and drive output.
// - wrap from FFFFH to 0000H sets overflow flag and overflow interrupt.
// - wrap by clear-on-match at FFFFH is a clear: no overflow.
// - return to zero by stopping the counter produces no overflow.
// - capture latches counter on valid edge and holds until next edge.
// - each valid trigger edge in capture mode with count run 1 captures into its register and raises its interrupt.
// - unit 0 selects register 0 capture trigger from pin or frame start pulse.
// - no capture while count run bit is 0.
// - compare registers are compared with the counter on every count.
// - count run 0 stops counter at 0000H; 1 lets it count.
// - unit clock gate 0 holds the unit in reset, except the origin select.
// - bus writes to a register in capture mode are discarded.
module tcc_unit #(
   parameter int          CNT_W   = 16,
   parameter int          UNIT_ID = 0
) (
   input  wire logic                i_clk,
   input  wire logic                i_srst,
   input  wire logic [31:0]         i_avs_address,
   input  wire logic                i_avs_read,
   input  wire logic                i_avs_write,
   input  wire logic [31:0]         i_avs_writedata,
   input  wire logic [3:0]          i_avs_byteenable,
   output logic      [31:0]         o_avs_readdata,
   output logic                     o_avs_waitrequest,
   input  wire logic                i_trig_in0,
   input  wire logic                i_trig_in1,
   input  wire logic                i_frame_start_pulse,
   output logic                     o_pulse_out,
   output logic                     o_cap_cmp_irq0,
   output logic                     o_cap_cmp_irq1,
   output logic                     o_overflow_irq
);
   import tcc_pkg::*;

   // refuse parameter values that the logic cannot serve
   if (CNT_W != 16 || UNIT_ID < 0 || UNIT_ID > 1) begin : g_bad_param
      $error("tcc_unit: counter must be 16 bits, unit id 0 or 1");
   end

   localparam logic [31:0] IDX_EDGE = (UNIT_ID == 0) ? IDX_EDGE0 : IDX_EDGE1;

   // valid edge decode for one trigger input
   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic       cur,
                                     input logic       prev);
      logic rise;
      logic fall;
      rise = cur & ~prev;
      fall = ~cur & prev;
      case (sel)
         EDGE_FALL: edge_hit = fall;
         EDGE_RISE: edge_hit = rise;
         EDGE_BOTH: edge_hit = rise | fall;
         default:   edge_hit = 1'b0;
      endcase
   endfunction

   // bus access state
   logic              ack;
   logic              next_ack;
   logic [31:0]       rdata;
   logic [31:0]       next_rdata;
   logic              req;
   logic              wr_go;

   // unit state
   logic [7:0]        ctrl0;
   logic [7:0]        next_ctrl0;
   logic [7:0]        ctrl1;
   logic [7:0]        next_ctrl1;
   logic [7:0]        edge_sel;
   logic [7:0]        next_edge_sel;
   logic [7:0]        origin;
   logic [7:0]        next_origin;
   logic [CNT_W-1:0]  cnt;
   logic [CNT_W-1:0]  next_cnt;
   logic [CNT_W-1:0]  ccr [2];
   logic [CNT_W-1:0]  next_ccr [2];
   logic              advanced;
   logic              next_advanced;
   logic              active;
   logic              next_active;
   logic              pin_lvl;
   logic              next_pin_lvl;
   logic [1:0]        irq_cc;
   logic [1:0]        next_irq_cc;
   logic              irq_ovf;
   logic              next_irq_ovf;

   // trigger synchronisers: stage a, stage b, then previous value
   logic [1:0]        trig_a;
   logic [1:0]        trig_b;
   logic [1:0]        trig_c;
   logic              sof_prev;

   // decoded controls
   logic              gate;
   logic              run;
   logic [1:0]        cmp_mode;
   logic [1:0]        edge_now;
   logic [1:0]        trig_ev;
   logic [1:0]        match;
   logic              clr_hit;
   logic              wrap;
   logic              ena;
   logic              pol;

   assign gate     = ctrl0[C0_GATE];
   assign run      = ctrl0[C0_RUN];
   assign cmp_mode = {ctrl1[C1_MODE1], ctrl1[C1_MODE0]};
   assign ena      = ctrl1[C1_ENA];
   assign pol      = ctrl1[C1_POL];

   // request handshake: every access takes one wait state
   assign req               = i_avs_read | i_avs_write;
   assign o_avs_waitrequest = req & ~ack;
   assign o_avs_readdata    = rdata;
   assign wr_go             = i_avs_write & ack;
   assign next_ack          = req & ~ack;

   // trigger edge detection per input
   for (genvar g = 0; g < 2; g++) begin : g_trig
      logic pick_sof;
      if (g == 0 && UNIT_ID == 0) begin : g_sel
         assign pick_sof = origin[OR_SOF];
      end else begin : g_pin
         assign pick_sof = 1'b0;
      end
      assign edge_now[g] = edge_hit(edge_sel[2*g +: 2], trig_b[g], trig_c[g]);
      assign trig_ev[g]  = pick_sof ? (i_frame_start_pulse & ~sof_prev)
                                    : edge_now[g];
      // match only on a value reached by counting, never on the start value
      assign match[g] = cmp_mode[g] & run & advanced & (cnt == ccr[g]);
   end

   assign clr_hit = match[0] & ctrl1[C1_CLR];
   assign wrap    = run & (cnt == CNT_MAX) & ~clr_hit;

   // read data mux
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (i_avs_read && !ack) begin
         case (i_avs_address)
            IDX_CTRL0:  next_rdata[7:0]       = ctrl0;
            IDX_CTRL1:  next_rdata[7:0]       = ctrl1;
            IDX_EDGE:   next_rdata[7:0]       = edge_sel;
            IDX_ORIGIN: next_rdata[7:0]       = origin;
            IDX_CCR0:   next_rdata[CNT_W-1:0] = ccr[0];
            IDX_CCR1:   next_rdata[CNT_W-1:0] = ccr[1];
            IDX_COUNT:  next_rdata[CNT_W-1:0] = cnt;
            default:    next_rdata            = 32'h0000_0000;
         endcase
      end else if (ack) begin
         next_rdata = rdata;
      end
   end

   // unit next state: counter, capture/compare, flags, pulse output
   always_comb begin
      next_ctrl0    = ctrl0;
      next_ctrl1    = ctrl1;
      next_edge_sel = edge_sel;
      next_origin   = origin;
      next_ccr[0]   = ccr[0];
      next_ccr[1]   = ccr[1];
      next_advanced = run;
      next_irq_cc   = 2'b00;
      next_irq_ovf  = 1'b0;
      next_active   = active;
      // counter: held at zero while stopped, cleared on match, else counts
      if (!run) begin
         next_cnt = CNT_ZERO;
      end else if (clr_hit) begin
         next_cnt = CNT_ZERO;
      end else begin
         next_cnt = cnt + 16'h0001;
      end
      // capture and match events per register
      for (int k = 0; k < 2; k++) begin
         if (!cmp_mode[k] && run && trig_ev[k]) begin
            next_ccr[k]    = cnt;
            next_irq_cc[k] = 1'b1;
         end
         if (match[k]) begin
            next_irq_cc[k] = 1'b1;
         end
      end
      // pulse output: set by register 0, reset by register 1 (reset wins)
      if (!ena || !run) begin
         next_active = 1'b0;
      end else if (match[1]) begin
         next_active = 1'b0;
      end else if (match[0]) begin
         next_active = 1'b1;
      end
      if (wrap) begin
         next_irq_ovf = 1'b1;
      end
      // software writes
      if (wr_go && i_avs_byteenable[0]) begin
         case (i_avs_address)
            IDX_CTRL0: begin
               next_ctrl0[C0_GATE] = i_avs_writedata[C0_GATE];
               next_ctrl0[C0_CS_HI:C0_CS_LO] =
                  i_avs_writedata[C0_CS_HI:C0_CS_LO];
               // run may only start once the unit clock is on
               next_ctrl0[C0_RUN] = gate & i_avs_writedata[C0_RUN];
               if (!i_avs_writedata[C0_OVF]) begin
                  next_ctrl0[C0_OVF] = 1'b0;
               end
            end
            IDX_CTRL1:  next_ctrl1    = i_avs_writedata[7:0] & C1_WMASK;
            IDX_EDGE:   next_edge_sel = i_avs_writedata[7:0] & ES_WMASK;
            IDX_ORIGIN: next_origin   = {7'h00, i_avs_writedata[OR_SOF]};
            default:    next_origin   = origin;
         endcase
      end
      for (int k = 0; k < 2; k++) begin
         if (wr_go && cmp_mode[k]
             && i_avs_address == (k == 0 ? IDX_CCR0 : IDX_CCR1)) begin
            if (i_avs_byteenable[0]) begin
               next_ccr[k][7:0] = i_avs_writedata[7:0];
            end
            if (i_avs_byteenable[1]) begin
               next_ccr[k][15:8] = i_avs_writedata[15:8];
            end
         end
      end
      // overflow flag: a new wrap wins over a software clear
      if (wrap) begin
         next_ctrl0[C0_OVF] = 1'b1;
      end
      next_pin_lvl = next_active ? next_ctrl1[C1_POL]
                                 : ~next_ctrl1[C1_POL];
      // gate off: everything but the gate bit and origin back to reset
      if (!next_ctrl0[C0_GATE]) begin
         next_ctrl0    = C0_RESET;
         next_ctrl1    = C1_RESET;
         next_edge_sel = ES_RESET;
         next_cnt      = CNT_ZERO;
         next_ccr[0]   = CNT_ZERO;
         next_ccr[1]   = CNT_ZERO;
         next_advanced = 1'b0;
         next_active   = 1'b0;
         next_irq_cc   = 2'b00;
         next_irq_ovf  = 1'b0;
         next_pin_lvl  = ~C1_RESET[C1_POL];
      end
   end

   // register all state
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         ack      <= 1'b0;
         rdata    <= 32'h0000_0000;
         ctrl0    <= C0_RESET;
         ctrl1    <= C1_RESET;
         edge_sel <= ES_RESET;
         origin   <= OR_RESET;
         cnt      <= CNT_ZERO;
         ccr[0]   <= CNT_ZERO;
         ccr[1]   <= CNT_ZERO;
         advanced <= 1'b0;
         active   <= 1'b0;
         pin_lvl  <= ~C1_RESET[C1_POL];
         irq_cc   <= 2'b00;
         irq_ovf  <= 1'b0;
         trig_a   <= 2'b00;
         trig_b   <= 2'b00;
         trig_c   <= 2'b00;
         sof_prev <= 1'b0;
      end else begin
         ack      <= next_ack;
         rdata    <= next_rdata;
         ctrl0    <= next_ctrl0;
         ctrl1    <= next_ctrl1;
         edge_sel <= next_edge_sel;
         origin   <= next_origin;
         cnt      <= next_cnt;
         ccr[0]   <= next_ccr[0];
         ccr[1]   <= next_ccr[1];
         advanced <= next_advanced;
         active   <= next_active;
         pin_lvl  <= next_pin_lvl;
         irq_cc   <= next_irq_cc;
         irq_ovf  <= next_irq_ovf;
         trig_a   <= {i_trig_in1, i_trig_in0};
         trig_b   <= trig_a;
         trig_c   <= trig_b;
         sof_prev <= i_frame_start_pulse;
      end
   end

   assign o_pulse_out    = pin_lvl;
   assign o_cap_cmp_irq0 = irq_cc[0];
   assign o_cap_cmp_irq1 = irq_cc[1];
   assign o_overflow_irq = irq_ovf;
endmodule

`default_nettype wire

// File: test/tcc_props.sv
// concurrent checks on the capture/compare timer ports
`timescale 1ns/1ps
`default_nettype none
module tcc_props
   import tcc_pkg::*;
(
   input wire logic        i_clk,
   input wire logic        i_srst,
   input wire logic [31:0] i_avs_address,
   input wire logic        i_avs_read,
   input wire logic        i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0]  i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic        o_avs_waitrequest,
   input wire logic        i_trig_in0,
   input wire logic        i_trig_in1,
   input wire logic        i_frame_start_pulse,
   input wire logic        o_pulse_out,
   input wire logic        o_cap_cmp_irq0,
   input wire logic        o_cap_cmp_irq1,
   input wire logic        o_overflow_irq
);
   logic [7:0] c1, next_c1;
   logic       gate, next_gate, run, next_run, wdone, rdone, irq;
   assign wdone = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
   assign rdone = i_avs_read && !o_avs_waitrequest;
   assign irq   = o_cap_cmp_irq0 || o_cap_cmp_irq1;
   // shadow of the control bits as written over the bus
   always_comb begin
      next_c1   = c1;
      next_gate = gate;
      next_run  = run;
      // with the unit clock off, control writes are lost in the unit reset
      if (wdone && gate && i_avs_address == IDX_CTRL1) begin
         next_c1 = i_avs_writedata[7:0] & C1_WMASK;
      end
      if (wdone && i_avs_address == IDX_CTRL0) begin
         next_gate = i_avs_writedata[C0_GATE];
         next_run  = i_avs_writedata[C0_RUN] & gate & i_avs_writedata[C0_GATE];
         if (!i_avs_writedata[C0_GATE]) begin
            next_c1 = C1_RESET;
         end
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         c1   <= C1_RESET;
         gate <= 1'b0;
         run  <= 1'b0;
      end else begin
         c1   <= next_c1;
         gate <= next_gate;
         run  <= next_run;
      end
   end
   default clocking cb_main @(posedge i_clk); endclocking
   default disable iff (i_srst);
   a_reset_idle: assert property (
      $fell(i_srst) |-> !o_pulse_out) else $error("pulse out active at reset");
   a_idle_level: assert property (
      !(c1[C1_ENA] && run) && $stable(c1) && $stable(run)
      |-> o_pulse_out == !c1[C1_POL]) else $error("pulse out not idle");
   a_match_level: assert property (
      irq && c1[C1_ENA] && (&c1[1:0]) && run && $stable(c1) && $stable(run)
      |-> o_pulse_out == (c1[C1_POL] ^ o_cap_cmp_irq1))
      else $error("pulse out wrong at match");
   a_pulse_cause: assert property (
      $changed(o_pulse_out) && $stable(c1) && $past(c1) == $past(c1, 2)
      && $past(run)
      && $past(run, 2) |-> irq) else $error("pulse out moved without match");
   a_stop_no_cap: assert property (
      (!run) [*3] |-> !irq) else $error("interrupt while counter stopped");
   a_stop_no_ovf: assert property (
      $fell(run) |=> !o_overflow_irq [*3]) else $error("overflow after stop");
   a_ovf_single: assert property (
      o_overflow_irq |=> !o_overflow_irq [*8]) else $error("overflow repeats");
   a_ctrl1_read: assert property (
      rdone && i_avs_address == IDX_CTRL1 |-> o_avs_readdata[7:0] == c1)
      else $error("control read mismatch");
   c_pwm_set: cover property (o_cap_cmp_irq0 && c1[C1_ENA]);
   c_overflow: cover property (o_overflow_irq);
   c_ctrl_read: cover property (rdone && i_avs_address == IDX_CTRL1);
endmodule

bind tcc_unit tcc_props i_props (.*);
`default_nettype wire

// File: test/tcc_pins.sv
// model of the trigger pins and frame start source facing the timer
`timescale 1ns/1ps
`default_nettype none
module tcc_pins (
   input  wire logic i_clk,
   output logic      o_trig_in0,
   output logic      o_trig_in1,
   output logic      o_frame_start_pulse
);
   initial begin
      o_trig_in0          = 1'b0;
      o_trig_in1          = 1'b0;
      o_frame_start_pulse = 1'b0;
   end
   // change one pin after an edge, then hold it past the sync delay
   task automatic drive(input int pin, input logic v);
      @(posedge i_clk);
      if (pin == 0) begin
         o_trig_in0 <= v;
      end else if (pin == 1) begin
         o_trig_in1 <= v;
      end else begin
         o_frame_start_pulse <= v;
      end
      repeat (8) @(posedge i_clk);
   endtask
endmodule
`default_nettype wire

// File: test/tcc_unit_tb_top.sv
// self-checking bench for the capture/compare timer unit
`timescale 1ns/1ps
`default_nettype none
module tcc_unit_tb_top;
   import tcc_pkg::*;
   typedef struct {logic [31:0] a, d, e;} tcc_row_t;
   logic        i_clk, i_srst = 1'b1, rd = 1'b0, wr = 1'b0, wreq, t0, t1;
   logic        sof, pout, irq0, irq1, ovf;
   logic [31:0] adr = '0, wdat = '0, rdat, q, q2;
   int          failures, cmp_count, cyc, n0, n1, nov, last0, last1, gap0;
   int          m, m1;
   logic [1:0]  codes [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
   tcc_row_t    rows [8];
   tcc_unit #(.CNT_W(16), .UNIT_ID(0)) i_dut (
      .i_clk(i_clk), .i_srst(i_srst), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
      .i_avs_byteenable(4'h3), .o_avs_readdata(rdat),
      .o_avs_waitrequest(wreq), .i_trig_in0(t0), .i_trig_in1(t1),
      .i_frame_start_pulse(sof), .o_pulse_out(pout),
      .o_cap_cmp_irq0(irq0), .o_cap_cmp_irq1(irq1), .o_overflow_irq(ovf));
   tcc_pins i_pins (.i_clk(i_clk), .o_trig_in0(t0), .o_trig_in1(t1),
      .o_frame_start_pulse(sof));
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   // tally cycles and interrupt pulses; a run past its ceiling fails
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (irq0) begin
         n0    <= n0 + 1;
         gap0  <= cyc - last0;
         last0 <= cyc;
      end
      if (irq1) begin
         n1    <= n1 + 1;
         last1 <= cyc;
      end
      if (ovf) begin
         nov <= nov + 1;
      end
      if (cyc == 90000) begin
         failures++;
         finish_test();
      end
   end
   // one bus transfer, held until waitrequest is seen low
   task automatic bus(input logic [31:0] a, input logic [31:0] d,
                      input logic w, output logic [31:0] r);
      adr  <= a;
      wdat <= d;
      wr   <= w;
      rd   <= !w;
      @(posedge i_clk);
      while (wreq !== 1'b0) @(posedge i_clk);
      r = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic wreg(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(a, d, 1'b1, x);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // register rows first, then the timed scenarios
   initial begin
      rows = '{'{IDX_CTRL0, 32'h0000_0001, 32'h0000_0001},
               '{IDX_CCR0, 32'h0000_1234, 32'h0000_0000},
               '{IDX_EDGE0, 32'h0000_00FF, 32'h0000_000F},
               '{32'hFFFF_F27C, 32'h0000_00FF, 32'h0000_0000},
               '{IDX_CTRL1, 32'h0000_00FF, 32'h0000_006B},
               '{IDX_CCR0, 32'h0000_1234, 32'h0000_1234},
               '{IDX_COUNT, 32'h0000_0055, 32'h0000_0000},
               '{IDX_CTRL1, 32'h0000_0020, 32'h0000_0020}};
      repeat (6) @(posedge i_clk);
      i_srst <= 1'b0;
      @(posedge i_clk);
      foreach (rows[i]) begin
         wreg(rows[i].a, rows[i].d);
         bus(rows[i].a, '0, 1'b0, q);
         chk(q, rows[i].e);
      end
      // pulse train: match 0 sets the output, match 1 clears it
      wreg(IDX_CTRL1, 32'h0000_0063);
      wreg(IDX_CCR0, 32'h0000_0005);
      wreg(IDX_CCR1, 32'h0000_0009);
      m = n0;
      m1 = n1;
      wreg(IDX_CTRL0, 32'h0000_0003);
      repeat (40) if (n0 == m) @(posedge i_clk);
      chk(pout, 1'b1);
      repeat (40) if (n1 == m1) @(posedge i_clk);
      chk(pout, 1'b0);
      chk(last1 - last0, 4);
      repeat (66000) if (nov == 0) @(posedge i_clk);
      bus(IDX_CTRL0, '0, 1'b0, q);
      chk(q[7:0], 8'h83);
      wreg(IDX_CTRL0, 32'h0000_0001);
      repeat (4) @(posedge i_clk);
      bus(IDX_COUNT, '0, 1'b0, q);
      chk(q, 0);
      chk(nov, 1);
      // clear on match with the output disabled and low active
      wreg(IDX_CTRL1, 32'h0000_000B);
      wreg(IDX_CCR0, 32'h0000_0003);
      wreg(IDX_CTRL0, 32'h0000_0003);
      repeat (30) @(posedge i_clk);
      chk(gap0, 4);
      chk(pout, 1'b1);
      // capture checked on every edge code, code 10 capturing nothing; counter stopped for each change
      wreg(IDX_CTRL0, 32'h0000_0001);
      wreg(IDX_CTRL1, 32'h0000_0020);
      foreach (codes[k]) begin
         wreg(IDX_CTRL0, 32'h0000_0001);
         wreg(IDX_EDGE0, {28'h000_0000, codes[k], codes[k]});
         wreg(IDX_CTRL0, 32'h0000_0003);
         m = n0;
         m1 = n1;
         i_pins.drive(0, 1'b1);
         i_pins.drive(1, 1'b1);
         chk(n0 - m, codes[k][0]);
         chk(n1 - m1, codes[k][0]);
         m = n0;
         m1 = n1;
         i_pins.drive(0, 1'b0);
         i_pins.drive(1, 1'b0);
         chk(n0 - m, codes[k][0] == codes[k][1]);
         chk(n1 - m1, codes[k][0] == codes[k][1]);
      end
      wreg(IDX_CTRL0, 32'h0000_0001);
      wreg(IDX_EDGE0, 32'h0000_0001);
      wreg(IDX_CTRL0, 32'h0000_0003);
      i_pins.drive(0, 1'b1);
      bus(IDX_CCR0, '0, 1'b0, q);
      bus(IDX_CCR0, '0, 1'b0, q2);
      chk(q2, q);
      chk(q != 0, 1'b1);
      wreg(IDX_CTRL0, 32'h0000_0001);
      m = n0;
      i_pins.drive(0, 1'b0);
      i_pins.drive(0, 1'b1);
      chk(n0 - m, 0);
      wreg(IDX_ORIGIN, 32'h0000_0001);
      wreg(IDX_CTRL0, 32'h0000_0003);
      i_pins.drive(0, 1'b0);
      i_pins.drive(0, 1'b1);
      chk(n0 - m, 0);
      i_pins.drive(2, 1'b1);
      i_pins.drive(2, 1'b0);
      chk(n0 - m, 1);
      // gate off, then a bus reset with low active polarity set
      wreg(IDX_CTRL0, 32'h0000_0001);
      wreg(IDX_CTRL1, 32'h0000_000B);
      wreg(IDX_CTRL0, '0);
      bus(IDX_CTRL1, '0, 1'b0, q);
      chk(q, 32'h0000_0020);
      bus(IDX_EDGE0, '0, 1'b0, q);
      chk(q, 32'h0000_0000);
      bus(IDX_CCR0, '0, 1'b0, q);
      chk(q, 32'h0000_0000);
      wreg(IDX_CTRL0, 32'h0000_0001);
      wreg(IDX_CTRL1, '0);
      @(posedge i_clk);
      chk(pout, 1'b1);
      i_srst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_srst <= 1'b0;
      @(posedge i_clk);
      chk(pout, 1'b0);
      bus(IDX_CTRL1, '0, 1'b0, q);
      chk(q, 32'h0000_0020);
      finish_test();
   end
endmodule
`default_nettype wire
